// ===== design/pes_event_latch.sv
// Live status and change latch registers for the internal event sources.
`timescale 1ns/1ns
module pes_event_latch
  import pes_pkg::*;
#(
  parameter int SRC_W = pes_pkg::NUM_SRC
) (
  // Clock and reset.
  input wire logic core_clk,
  input wire logic rst,
  // Internal event source levels.
  input wire logic bus_supply_monitor_good,
  input wire logic overstress_detect,
  input wire logic id_pin_floating,
  input wire logic id_resistor_c_detect,
  input wire logic id_resistor_b_detect,
  input wire logic id_resistor_a_detect,
  input wire logic session_valid_comparator,
  // Per-source masks from the enable registers kept elsewhere.
  input wire logic [pes_pkg::NUM_SRC-1:0] rise_enable,
  input wire logic [pes_pkg::NUM_SRC-1:0] fall_enable,
  // Mode entry pulses from the transceiver control.
  input wire logic low_power_entry,
  input wire logic serial_mode_entry,
  // Register read port from the link.
  input wire logic reg_rd_strobe,
  input wire logic [pes_pkg::ADDR_W-1:0] reg_addr,
  // Read answer toward the link.
  output logic [pes_pkg::DATA_W-1:0] reg_rd_data,
  output logic reg_rd_valid
);

  import pes_pkg::*;

  // The eight-bit registers leave exactly one reserved bit on top, so the
  // source count is fixed and is refused at elaboration if it differs.
  if (SRC_W != NUM_SRC || SRC_W >= DATA_W) begin : g_bad_src_w
    $error("pes_event_latch: SRC_W must equal the source count");
  end

  // Source levels gathered at their register positions.
  logic [NUM_SRC-1:0] src_vec;
  // Masked change pulses from the detector.
  logic [NUM_SRC-1:0] evt_pulse;
  // Change latch contents.
  logic [NUM_SRC-1:0] latch_reg;
  // Next value of the change latch.
  logic [NUM_SRC-1:0] latch_next;
  // Any reason to empty the latch this cycle.
  logic latch_clear;
  // The link reads the latch this cycle.
  logic latch_read;

  // Pad a source vector into a register word with the reserved bit low.
  function automatic logic [DATA_W-1:0] to_word(
    input logic [NUM_SRC-1:0] bits
  );
    to_word = {1'b0, bits};
  endfunction

  // Each source lands on its fixed bit in both registers.
  always_comb begin
    src_vec = '0;
    src_vec[BIT_SUPPLY_GOOD] = bus_supply_monitor_good;
    src_vec[BIT_OVERSTRESS] = overstress_detect;
    src_vec[BIT_ID_PIN_FLOATING] = id_pin_floating;
    src_vec[BIT_ID_RES_C] = id_resistor_c_detect;
    src_vec[BIT_ID_RES_B] = id_resistor_b_detect;
    src_vec[BIT_ID_RES_A] = id_resistor_a_detect;
    src_vec[BIT_SESSION_VALID] = session_valid_comparator;
  end

  // Change detection with the direction masks applied.
  pes_edge_detect #(
    .WIDTH(NUM_SRC)
  ) u_edge (
    .core_clk(core_clk),
    .rst(rst),
    .src_level(src_vec),
    .rise_en(rise_enable),
    .fall_en(fall_enable),
    .event_pulse(evt_pulse)
  );

  // Clear sources: a link read of the change latch, low power entry or serial mode entry.
  // Serial entry clears whatever the clock suspend setting says.
  always_comb begin
    latch_read = reg_rd_strobe && (reg_addr == CHANGE_LATCH_ADDR);
    latch_clear = latch_read || low_power_entry ||
                  serial_mode_entry;
  end

  // Set wins over clear so that a coincident change is reported on the
  // next read instead of vanishing with the cleared value.
  always_comb begin
    if (latch_clear) begin
      latch_next = evt_pulse;
    end else begin
      latch_next = latch_reg | evt_pulse;
    end
  end

  // Change latch storage.
  always_ff @(posedge core_clk) begin
    if (rst) begin
      latch_reg <= REG_RESET[NUM_SRC-1:0];
    end else begin
      latch_reg <= latch_next;
    end
  end

  // Read answer: live levels are sampled as of the read cycle, the latch
  // returns its value before the clear takes effect. There is no write
  // path, so link writes to these offsets change nothing.
  always_ff @(posedge core_clk) begin
    if (rst) begin
      reg_rd_data <= REG_RESET;
      reg_rd_valid <= 1'b0;
    end else begin
      reg_rd_valid <= reg_rd_strobe;
      if (reg_rd_strobe) begin
        case (reg_addr)
          LIVE_STATUS_ADDR: begin
            reg_rd_data <= to_word(src_vec);
          end
          CHANGE_LATCH_ADDR: begin
            reg_rd_data <= to_word(latch_reg);
          end
          default: begin
            reg_rd_data <= UNMAPPED_DATA;
          end
        endcase
      end
    end
  end

  // Live read returns the source levels of the read cycle.
  a_live_read_value: assert property (
    @(posedge core_clk) disable iff (rst)
    (reg_rd_strobe && reg_addr == LIVE_STATUS_ADDR) |=>
      (reg_rd_valid && reg_rd_data == {1'b0, $past(src_vec)}))
    else $error("live status read returned a wrong value");

  // Supply monitor level appears on bit six of the live read.
  a_supply_bit_map: assert property (
    @(posedge core_clk) disable iff (rst)
    (reg_rd_strobe && reg_addr == LIVE_STATUS_ADDR) |=>
      (reg_rd_data[BIT_SUPPLY_GOOD] == $past(bus_supply_monitor_good) &&
       reg_rd_data[BIT_SESSION_VALID] == $past(session_valid_comparator)))
    else $error("live status bit mapping is wrong");

  // A masked-in change is latched on the next edge.
  a_event_sets_latch: assert property (
    @(posedge core_clk) disable iff (rst)
    (evt_pulse != '0) |=> ((latch_reg & $past(evt_pulse)) ==
                           $past(evt_pulse)))
    else $error("change event was not latched");

  // Latch read returns the pre-clear contents.
  a_latch_read_value: assert property (
    @(posedge core_clk) disable iff (rst)
    latch_read |=> (reg_rd_data == {1'b0, $past(latch_reg)}))
    else $error("latch read returned a wrong value");

  // A read empties the latch except for a coincident event.
  a_read_clears: assert property (
    @(posedge core_clk) disable iff (rst)
    latch_read |=> (latch_reg == $past(evt_pulse)))
    else $error("latch read did not clear the latch");

  // Low power entry clears the latch.
  a_lowpower_clears: assert property (
    @(posedge core_clk) disable iff (rst)
    low_power_entry |=> (latch_reg == $past(evt_pulse)))
    else $error("low power entry did not clear the latch");

  // Serial mode entry clears the latch.
  a_serial_clears: assert property (
    @(posedge core_clk) disable iff (rst)
    serial_mode_entry |=> (latch_reg == $past(evt_pulse)))
    else $error("serial mode entry did not clear the latch");

  // Without clear or event the latch holds. The reset term keeps an
  // attempt started on a reset edge from comparing across that reset,
  // where the latch is emptied on purpose.
  a_latch_holds: assert property (
    @(posedge core_clk) disable iff (rst)
    (!rst && !latch_clear && evt_pulse == '0) |=> $stable(latch_reg))
    else $error("latch changed without a cause");

  // A change pulse needs a real change in an enabled direction.
  a_change_masked: assert property (
    @(posedge core_clk) disable iff (rst)
    (evt_pulse != '0) |->
      ((evt_pulse & ~(src_vec ^ $past(src_vec))) == '0 &&
       (evt_pulse & ~((src_vec & rise_enable) |
                      (~src_vec & fall_enable))) == '0))
    else $error("change pulse without an enabled change");

  // Reserved bit reads zero and unmapped reads return zero.
  a_reserved_zero: assert property (
    @(posedge core_clk) disable iff (rst)
    (reg_rd_strobe && reg_addr != LIVE_STATUS_ADDR &&
     reg_addr != CHANGE_LATCH_ADDR) |=>
      (reg_rd_valid && reg_rd_data == UNMAPPED_DATA &&
       !reg_rd_data[BIT_RESERVED]))
    else $error("reserved or unmapped read not zero");

  // The answer strobe is one cycle per request.
  a_valid_pulse: assert property (
    @(posedge core_clk) disable iff (rst)
    !reg_rd_strobe |=> !reg_rd_valid)
    else $error("read answer without a request");

endmodule // pes_event_latch

// ===== design/pes_pkg.sv
// Package of constants for the event status and change latch block.
package pes_pkg;

  // Register address width of the link register port.
  localparam int ADDR_W = 8;
  // Register data width of the link register port.
  localparam int DATA_W = 8;
  // Number of internal event sources.
  localparam int NUM_SRC = 7;

  // Live status register offset.
  localparam logic [7:0] LIVE_STATUS_ADDR = 8'h83;
  // Change latch register offset.
  localparam logic [7:0] CHANGE_LATCH_ADDR = 8'h84;

  // Reset value shared by both registers.
  localparam logic [7:0] REG_RESET = 8'h00;
  // Value returned for an unmapped address.
  localparam logic [7:0] UNMAPPED_DATA = 8'h00;

  // Bit positions of the event sources inside both registers.
  localparam int BIT_SESSION_VALID = 0;
  localparam int BIT_ID_RES_A = 1;
  localparam int BIT_ID_RES_B = 2;
  localparam int BIT_ID_RES_C = 3;
  localparam int BIT_ID_PIN_FLOATING = 4;
  localparam int BIT_OVERSTRESS = 5;
  localparam int BIT_SUPPLY_GOOD = 6;
  // Reserved bit, always read as zero.
  localparam int BIT_RESERVED = 7;

endpackage : pes_pkg

// ===== design/pes_edge_detect.sv
// Masked change detector for the internal event sources.
`timescale 1ns/1ns
module pes_edge_detect #(
  parameter int WIDTH = 7
) (
  // Clock and reset.
  input wire logic core_clk,
  input wire logic rst,
  // Source levels and per-bit masks.
  input wire logic [WIDTH-1:0] src_level,
  input wire logic [WIDTH-1:0] rise_en,
  input wire logic [WIDTH-1:0] fall_en,
  // One-cycle pulse per source on an unmasked change.
  output logic [WIDTH-1:0] event_pulse
);

  // Level seen in the previous cycle, the reference for a change.
  logic [WIDTH-1:0] prev_reg;
  // Holds off the first compare so reset release is not an event.
  logic armed_reg;

  // Track the previous source level.
  always_ff @(posedge core_clk) begin
    if (rst) begin
      prev_reg <= '0;
      armed_reg <= 1'b0;
    end else begin
      prev_reg <= src_level;
      armed_reg <= 1'b1;
    end
  end

  // A change counts only where the matching direction is enabled.
  always_comb begin
    if (armed_reg) begin
      event_pulse = (src_level & ~prev_reg & rise_en) |
                    (~src_level & prev_reg & fall_en);
    end else begin
      event_pulse = '0;
    end
  end

endmodule // pes_edge_detect

// ===== sim/pes_link_model.sv
// Behavioural link controller that issues register reads toward the block.
`timescale 1ns/1ns
module pes_link_model
  import pes_pkg::*;
(
  // Clock.
  input wire logic core_clk,
  // Read request toward the block.
  output logic reg_rd_strobe,
  output logic [pes_pkg::ADDR_W-1:0] reg_addr,
  // Read answer from the block.
  input wire logic [pes_pkg::DATA_W-1:0] reg_rd_data,
  input wire logic reg_rd_valid
);
  initial begin
    reg_rd_strobe = 1'b0;
    reg_addr = 8'h00;
  end

  // One read; call right after a rising edge, returns on a rising edge.
  // The address is inverted once released so a stale value is never reused.
  task automatic read(input logic [7:0] a, output logic [7:0] d,
                      output logic ok);
    ok = 1'b0;
    d = 8'h00;
    reg_rd_strobe <= 1'b1;
    reg_addr <= a;
    @(posedge core_clk);
    reg_rd_strobe <= 1'b0;
    reg_addr <= ~a;
    // The answer is sampled mid-cycle, away from the launching edge.
    for (int i = 0; i < 4 && !ok; i++) begin
      @(negedge core_clk);
      if (reg_rd_valid === 1'b1) begin
        d = reg_rd_data;
        ok = 1'b1;
      end
    end
    @(posedge core_clk);
  endtask
endmodule // pes_link_model

// ===== sim/phy_event_status_latch_tb.sv
// Self-checking bench for the event status and change latch block.
`timescale 1ns/1ns
module phy_event_status_latch_tb;
  import pes_pkg::*;
  logic core_clk = 1'b0;
  logic rst = 1'b1;
  // Source levels, bit positions as in both registers.
  logic [6:0] src = 7'h00;
  logic [6:0] rise_en = 7'h00;
  logic [6:0] fall_en = 7'h00;
  logic lp = 1'b0;
  logic ser = 1'b0;
  logic strobe;
  logic [7:0] addr;
  logic [7:0] rdata;
  logic valid;
  int err_total = 0;
  int samples_checked = 0;

  // Free-running 100 MHz clock.
  always #5 core_clk = ~core_clk;

  pes_event_latch uut (
    .core_clk(core_clk), .rst(rst),
    .bus_supply_monitor_good(src[6]), .overstress_detect(src[5]),
    .id_pin_floating(src[4]), .id_resistor_c_detect(src[3]),
    .id_resistor_b_detect(src[2]), .id_resistor_a_detect(src[1]),
    .session_valid_comparator(src[0]),
    .rise_enable(rise_en), .fall_enable(fall_en),
    .low_power_entry(lp), .serial_mode_entry(ser),
    .reg_rd_strobe(strobe), .reg_addr(addr),
    .reg_rd_data(rdata), .reg_rd_valid(valid));

  pes_link_model link (
    .core_clk(core_clk), .reg_rd_strobe(strobe), .reg_addr(addr),
    .reg_rd_data(rdata), .reg_rd_valid(valid));

  // Verdict and end of run; also reached when a wait runs out.
  task automatic close_out();
    if (err_total == 0 && samples_checked > 0) begin
      $display("bench passed");
    end else begin
      $display("bench failed");
    end
    $finish;
  endtask

  // Compare one value with its expectation.
  task automatic check(input logic [7:0] seen, input logic [7:0] exp);
    samples_checked++;
    if (seen !== exp) begin
      err_total++;
      $display("BAD %0t read %h expected %h", $time, seen, exp);
    end
  endtask

  // Read one register and compare; a missing answer ends the run.
  task automatic rd(input logic [7:0] a, input logic [7:0] exp);
    logic [7:0] d;
    logic ok;
    link.read(a, d, ok);
    if (!ok) begin
      err_total++;
      $display("BAD %0t no answer", $time);
      close_out();
    end else begin
      check(d, exp);
    end
  endtask

  // New source levels; the change is judged at the next edge.
  task automatic setsrc(input logic [6:0] v);
    src <= v;
    repeat (2) @(posedge core_clk);
  endtask

  initial begin
    repeat (10) @(posedge core_clk);
    rst <= 1'b0;
    repeat (2) @(posedge core_clk);
    rd(LIVE_STATUS_ADDR, REG_RESET);
    rd(CHANGE_LATCH_ADDR, REG_RESET);
    rd(8'h85, UNMAPPED_DATA);
    rise_en <= 7'h7f;
    setsrc(7'h55);
    rd(LIVE_STATUS_ADDR, 8'h55);
    rd(CHANGE_LATCH_ADDR, 8'h55);
    rd(CHANGE_LATCH_ADDR, 8'h00);
    // Falls are masked here, so only the rising bits may latch.
    setsrc(7'h2a);
    rd(CHANGE_LATCH_ADDR, 8'h2a);
    fall_en <= 7'h7f;
    // Each mode entry must wipe a latch that holds pending events.
    for (int k = 0; k < 2; k++) begin
      setsrc(k ? 7'h2a : 7'h00);
      lp <= (k == 0);
      ser <= (k == 1);
      @(posedge core_clk);
      lp <= 1'b0;
      ser <= 1'b0;
      @(posedge core_clk);
      rd(CHANGE_LATCH_ADDR, 8'h00);
    end
    // Source change lands on the very edge that takes the clearing read.
    src <= 7'h2b;
    rd(CHANGE_LATCH_ADDR, 8'h00);
    rd(CHANGE_LATCH_ADDR, 8'h01);
    // Both masks off: no change may latch, and a walking one checks each
    // live status position on its own.
    rise_en <= 7'h00;
    fall_en <= 7'h00;
    for (int b = 0; b < 7; b++) begin
      setsrc(7'(1 << b));
      rd(LIVE_STATUS_ADDR, 8'(1 << b));
    end
    rd(CHANGE_LATCH_ADDR, 8'h00);
    // Only the enabled fall of the top source may latch.
    fall_en <= 7'h7f;
    setsrc(7'h00);
    rd(CHANGE_LATCH_ADDR, 8'h40);
    rise_en <= 7'h7f;
    // A second reset in mid-run drops a pending event.
    setsrc(7'h2f);
    rst <= 1'b1;
    @(posedge core_clk);
    rst <= 1'b0;
    repeat (2) @(posedge core_clk);
    rd(CHANGE_LATCH_ADDR, REG_RESET);
    close_out();
  end
endmodule // phy_event_status_latch_tb
